/* File: core/lpi_ctrl.sv */
// Memory controller end: power-up sequencer with Avalon-MM registers
`timescale 1ns/1ps
module lpi_ctrl
	import lpi_pkg::*;
#(
	parameter int NOP_IDLE_CYCLES = NOP_IDLE_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	lpi_link_if.ctrl         link
);
	typedef enum logic [3:0] {
		ST_OFF, ST_LOW_WAIT, ST_NOP_IDLE, ST_PREA, ST_RESET, ST_POST_RESET, ST_POLL,
		ST_POLL_WAIT, ST_CAL, ST_CAL_WAIT, ST_SET_FEAT, ST_SET_LAT, ST_SET_IO, ST_READY
	} lpi_ctrl_st_t;

	// Extra link period on the post-reset, auto-init and calibration waits covers the device's sampling delay
	localparam int LOW_WAIT_CYC  = (POST_RAMP_LOW_CYC > PRE_ENABLE_CYC) ? POST_RAMP_LOW_CYC : PRE_ENABLE_CYC;
	localparam int RESET_WAIT    = POST_RESET_IDLE_CYC + LINK_PERIOD_CYC;
	localparam int AUTO_INIT_END = AUTO_INIT_MAX_CYC + LINK_PERIOD_CYC;
	localparam int CAL_WAIT      = INIT_CAL_CYC + LINK_PERIOD_CYC;

	// Command word {cmd, ma, op} driven for each state
	function automatic logic [18:0] cmd_of(input lpi_ctrl_st_t s, input logic [23:0] cfg);
		logic [18:0] w;
		w = {CMD_NOP, OP_ZERO, OP_ZERO};
		unique case (s)
			ST_PREA:  w = {CMD_PREA, OP_ZERO, OP_ZERO};
			ST_RESET:    w = {CMD_MODE_WR, MA_RESET, OP_ZERO};
			ST_POLL:     w = {CMD_MODE_RD, MA_DEVICE_INFO, OP_ZERO};
			ST_CAL:      w = {CMD_MODE_WR, MA_IO_CALIB, OP_CAL_INIT};
			ST_SET_FEAT: w = {CMD_MODE_WR, MA_FEATURE_ONE, cfg[7:0]};
			ST_SET_LAT:  w = {CMD_MODE_WR, MA_LATENCY_CFG, cfg[15:8]};
			ST_SET_IO:   w = {CMD_MODE_WR, MA_IO_CFG, cfg[23:16]};
			default:  w = {CMD_NOP, OP_ZERO, OP_ZERO};
		endcase
		return w;
	endfunction

	lpi_ctrl_st_t state_q;
	lpi_ctrl_st_t state_d;
	logic [3:0]   div_q;
	logic         ck_q;
	logic         cke_q;
	logic [18:0]  cmdw_q;
	logic [31:0]  cnt_q;
	logic [31:0]  age_q;
	logic         rise_seen_q;
	logic [7:0]   dq_s1_q;
	logic [7:0]   dq_s2_q;
	logic [7:0]   info_q;
	logic         timed_out_q;
	logic         start_q;
	logic         off_q;
	logic         reinit_q;
	logic [23:0]  mode_cfg_q;
	logic         ack_q;
	logic [31:0]  rdata_q;

	// Link clock divider runs from reset, so it is stable before cke
	wire div_end = (div_q == 4'(LINK_HALF_CYC - 1));
	wire fall_en = div_end & ck_q;
	wire rise_en = div_end & ~ck_q;
	wire req     = avs_read | avs_write;
	wire wr_take = avs_write & ack_q;
	wire wr_ctrl = wr_take & (avs_address == REG_CTRL);
	wire wr_cfg  = wr_take & (avs_address == REG_MODE_CFG);
	wire cnt_ge_low   = (cnt_q >= 32'(LOW_WAIT_CYC));
	wire cnt_ge_nop   = (cnt_q >= 32'(NOP_IDLE_CYCLES));
	wire age_ge_reset = (age_q >= 32'(RESET_WAIT));
	wire age_ge_max   = (age_q >= 32'(AUTO_INIT_END));
	wire cnt_ge_cal   = (cnt_q >= 32'(CAL_WAIT));
	// Flag sampled at the second rise, while the device still drives
	wire poll_take = rise_en & ~rise_seen_q & (state_q == ST_POLL_WAIT);
	wire init_done = ~dq_s2_q[AUTO_INIT_BIT];
	wire can_reset = (state_q != ST_OFF) & (state_q != ST_LOW_WAIT) & (state_q != ST_NOP_IDLE);

	always_comb begin
		state_d = state_q;
		if (off_q) begin
			state_d = ST_OFF;
		end else if (reinit_q && can_reset) begin
			state_d = ST_RESET;
		end else begin
			unique case (state_q)
				ST_OFF:        state_d = start_q ? ST_LOW_WAIT : ST_OFF;
				ST_LOW_WAIT:   state_d = cnt_ge_low ? ST_NOP_IDLE : ST_LOW_WAIT;
				ST_NOP_IDLE:   state_d = cnt_ge_nop ? ST_PREA : ST_NOP_IDLE;
				ST_PREA:       state_d = ST_RESET;
				ST_RESET:      state_d = ST_POST_RESET;
				ST_POST_RESET: state_d = age_ge_reset ? ST_POLL : ST_POST_RESET;
				ST_POLL:       state_d = ST_POLL_WAIT;
				ST_POLL_WAIT:  state_d = ST_POLL_WAIT;
				ST_CAL:        state_d = ST_CAL_WAIT;
				ST_CAL_WAIT:   state_d = cnt_ge_cal ? ST_SET_FEAT : ST_CAL_WAIT;
				ST_SET_FEAT:   state_d = ST_SET_LAT;
				ST_SET_LAT:    state_d = ST_SET_IO;
				ST_SET_IO:     state_d = ST_READY;
				ST_READY:      state_d = ST_READY;
			endcase
		end
	end

	// Poll result is kept until the next link fall moves the sequence on
	wire poll_ready = (state_q == ST_POLL_WAIT) & rise_seen_q;
	wire poll_again = poll_ready & ~(~info_q[AUTO_INIT_BIT] | age_ge_max);
	wire [3:0] st_mv = (poll_ready && state_d == ST_POLL_WAIT)
		? (poll_again ? ST_POLL : ST_CAL) : state_d;
	wire lpi_ctrl_st_t st_next = lpi_ctrl_st_t'(st_mv);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			div_q <= 4'h0;
			ck_q  <= 1'b0;
		end else begin
			div_q <= div_end ? 4'h0 : div_q + 4'h1;
			ck_q  <= div_end ? ~ck_q : ck_q;
		end
	end

	// All link changes happen at the link falling edge, half a period before sampling
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= ST_OFF;
			cke_q   <= 1'b0;
			cmdw_q  <= {CMD_NOP, OP_ZERO, OP_ZERO};
		end else if (fall_en) begin
			state_q <= st_next;
			cke_q   <= (st_next != ST_OFF) & (st_next != ST_LOW_WAIT);
			cmdw_q  <= cmd_of(st_next, mode_cfg_q);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_q       <= 32'h0000_0000;
			age_q       <= 32'h0000_0000;
			rise_seen_q <= 1'b0;
		end else begin
			cnt_q <= (fall_en && st_next != state_q) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
			age_q <= (fall_en && st_next == ST_RESET) ? 32'h0000_0000 : age_q + 32'h0000_0001;
			if (state_q != ST_POLL_WAIT) begin
				rise_seen_q <= 1'b0;
			end else if (rise_en) begin
				rise_seen_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dq_s1_q     <= 8'h00;
			dq_s2_q     <= 8'h00;
			info_q      <= 8'h00;
			timed_out_q <= 1'b0;
		end else begin
			dq_s1_q <= link.dq_in;
			dq_s2_q <= dq_s1_q;
			if (poll_take) begin
				info_q      <= dq_s2_q;
				timed_out_q <= ~init_done & age_ge_max;
			end
		end
	end

	// Order bits wait for the next link fall; a new write wins over the clear
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			start_q    <= 1'b0;
			off_q      <= 1'b0;
			reinit_q   <= 1'b0;
			mode_cfg_q <= MODE_CFG_RESET;
		end else begin
			start_q  <= (wr_ctrl & avs_writedata[CTRL_START]) | (start_q & ~fall_en);
			off_q    <= (wr_ctrl & avs_writedata[CTRL_POWER_OFF]) | (off_q & ~fall_en);
			reinit_q <= (wr_ctrl & avs_writedata[CTRL_REINIT]) | (reinit_q & ~fall_en);
			if (wr_cfg) begin
				mode_cfg_q <= avs_writedata[23:0];
			end
		end
	end

	// Fixed one wait state; unmapped reads give zero, writes are dropped
	wire [31:0] status_word = {16'h0000, info_q, 3'h0, timed_out_q, 4'(state_q)};
	wire [31:0] rd_mux = (avs_address == REG_STATUS) ? status_word
		: (avs_address == REG_MODE_CFG) ? {8'h00, mode_cfg_q} : 32'h0000_0000;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign link.ck         = ck_q;
	assign link.cke        = cke_q;
	assign link.cs_n       = 1'b0;
	assign link.cmd        = cmdw_q[18:16];
	assign link.ma         = cmdw_q[15:8];
	assign link.op         = cmdw_q[7:0];
endmodule

/* File: core/lpi_device.sv */
// Memory device end: auto-init, calibration and mode registers
`timescale 1ns/1ps
module lpi_device
	import lpi_pkg::*;
#(
	parameter int AUTO_INIT_CYC = DEV_AUTO_INIT_CYC,
	parameter int CAL_CYC       = DEV_CAL_CYC
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	lpi_link_if.dev         link,
	output logic            ready_out,
	output logic            auto_init_busy_out,
	output logic            bad_cmd_out,
	output logic [1:0]      cal_resistor_selftest_out,
	output logic [7:0]      feature_one_out,
	output logic [7:0]      latency_cfg_out,
	output logic [7:0]      io_cfg_out
);
	typedef enum logic [2:0] {DV_OFF, DV_WAIT_RESET, DV_AUTO_INIT, DV_IDLE_INIT, DV_CAL, DV_READY} lpi_dev_st_t;

	// Pin group: ck, cke, cs_n, cmd, ma, op
	logic [21:0] pin_s1_q;
	logic [21:0] pin_s2_q;
	logic        ck_prev_q;
	lpi_dev_st_t state_q;
	lpi_dev_st_t state_d;
	logic [31:0] timer_q;
	logic        auto_init_flag_q;
	logic [1:0]  cal_resistor_selftest_q;
	logic [7:0]  feature_one_reg_q;
	logic [7:0]  latency_cfg_reg_q;
	logic [7:0]  io_cfg_reg_q;
	logic [7:0]  dq_q;
	logic        dq_oe_q;
	logic        bad_q;

	wire       ck_s   = pin_s2_q[21];
	wire       cke_s  = pin_s2_q[20];
	wire       cs_n_s = pin_s2_q[19];
	wire [2:0] cmd_s  = pin_s2_q[18:16];
	wire [7:0] ma_s   = pin_s2_q[15:8];
	wire [7:0] op_s   = pin_s2_q[7:0];
	// Command counts only at a link rising edge with cke high
	wire rise    = ck_s & ~ck_prev_q;
	wire cmd_ok  = rise & cke_s & ~cs_n_s;
	wire is_mode_wr = cmd_ok & (cmd_s == CMD_MODE_WR);
	wire is_mode_rd = cmd_ok & (cmd_s == CMD_MODE_RD);
	wire is_rst  = is_mode_wr & (ma_s == MA_RESET);
	wire in_init = (state_q == DV_AUTO_INIT) | (state_q == DV_IDLE_INIT) | (state_q == DV_WAIT_RESET);
	// Only reads, NOPs, the reset command and power-down allowed while auto-init runs
	wire illegal = cmd_ok & (state_q == DV_AUTO_INIT) & ~is_mode_rd & ~is_rst & (cmd_s != CMD_NOP);
	wire timer_done = (timer_q == 32'h0000_0000);
	wire cfg_ok  = is_mode_wr & ~illegal & ((state_q == DV_IDLE_INIT) | (state_q == DV_READY));
	wire cal_go  = cfg_ok & (ma_s == MA_IO_CALIB);
	wire [7:0] info_word = {3'h0, cal_resistor_selftest_q, 2'h0, auto_init_flag_q};

	always_comb begin
		state_d = state_q;
		if (is_rst) begin
			state_d = DV_AUTO_INIT;
		end else begin
			unique case (state_q)
				DV_OFF:        state_d = (rise & cke_s) ? DV_WAIT_RESET : DV_OFF;
				DV_WAIT_RESET: state_d = DV_WAIT_RESET;
				DV_AUTO_INIT:  state_d = timer_done ? DV_IDLE_INIT : DV_AUTO_INIT;
				DV_IDLE_INIT:  state_d = cal_go ? DV_CAL : DV_IDLE_INIT;
				DV_CAL:        state_d = timer_done ? DV_READY : DV_CAL;
				DV_READY:      state_d = DV_READY;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pin_s1_q  <= 22'h00_0000;
			pin_s2_q  <= 22'h00_0000;
			ck_prev_q <= 1'b0;
		end else begin
			pin_s1_q  <= {link.ck, link.cke, link.cs_n, link.cmd, link.ma, link.op};
			pin_s2_q  <= pin_s1_q;
			ck_prev_q <= ck_s;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_q <= DV_OFF;
			timer_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			if (is_rst) begin
				timer_q <= AUTO_INIT_CYC;
			end else if (cal_go) begin
				timer_q <= CAL_CYC;
			end else if (!timer_done) begin
				timer_q <= timer_q - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			auto_init_flag_q        <= 1'b0;
			cal_resistor_selftest_q <= SELFTEST_NONE;
		end else begin
			if (is_rst) begin
				auto_init_flag_q <= 1'b1;
			end else if (state_q == DV_AUTO_INIT && timer_done) begin
				auto_init_flag_q <= 1'b0;
			end
			if (is_rst) begin
				cal_resistor_selftest_q <= SELFTEST_NONE;
			end else if (state_q == DV_CAL && timer_done) begin
				cal_resistor_selftest_q <= SELFTEST_OK;
			end
		end
	end

	// Writes to read-only or unknown addresses have no effect
	always_ff @(posedge clk_in) begin
		if (!rst_n_in || is_rst) begin
			feature_one_reg_q <= OP_ZERO;
			latency_cfg_reg_q <= OP_ZERO;
			io_cfg_reg_q      <= OP_ZERO;
		end else if (cfg_ok) begin
			if (ma_s == MA_FEATURE_ONE) feature_one_reg_q <= op_s;
			if (ma_s == MA_LATENCY_CFG) latency_cfg_reg_q <= op_s;
			if (ma_s == MA_IO_CFG) io_cfg_reg_q <= op_s;
		end
	end

	// Read data held from one link rise to the next
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dq_q    <= 8'h00;
			dq_oe_q <= 1'b0;
			bad_q   <= 1'b0;
		end else begin
			bad_q <= illegal;
			if (rise) begin
				dq_oe_q <= is_mode_rd & (in_init | (state_q == DV_READY) | (state_q == DV_CAL));
				dq_q    <= (ma_s == MA_DEVICE_INFO) ? info_word : 8'h00;
			end
		end
	end

	// Outputs stay released whenever the synchronised cke_s is low
	assign link.dq_oe  = dq_oe_q & cke_s;
	assign link.dq_out = dq_q;
	assign ready_out                 = (state_q == DV_READY);
	assign auto_init_busy_out        = auto_init_flag_q;
	assign bad_cmd_out               = bad_q;
	assign cal_resistor_selftest_out = cal_resistor_selftest_q;
	assign feature_one_out           = feature_one_reg_q;
	assign latency_cfg_out           = latency_cfg_reg_q;
	assign io_cfg_out                = io_cfg_reg_q;
endmodule

/* File: core/lpi_link_if.sv */
// Link between the memory controller end and the memory device end
`timescale 1ns/1ps
interface lpi_link_if;
	logic       ck;
	logic       cke;
	logic       cs_n;
	logic [2:0] cmd;
	logic [7:0] ma;
	logic [7:0] op;
	logic [7:0] dq_out;
	logic       dq_oe;
	logic [7:0] dq_in;
	// Undriven data bus reads as zero
	assign dq_in = dq_oe ? dq_out : 8'h00;
	modport ctrl (output ck, cke, cs_n, cmd, ma, op, input dq_in);
	modport dev (input ck, cke, cs_n, cmd, ma, op, output dq_out, dq_oe);
endinterface

/* File: core/lpi_pkg.sv */
// Shared constants for the memory power-up sequencer link and both ends
package lpi_pkg;
	localparam int CLK_PERIOD_NS        = 8;
	// Link clock made by the controller: 10 cycles = 80 ns, inside boot window
	localparam int LINK_HALF_CYC        = 5;
	localparam int LINK_PERIOD_CYC      = 2 * LINK_HALF_CYC;
	localparam int BOOT_CLK_MIN_NS      = 18;
	localparam int BOOT_CLK_MAX_NS      = 100;
	localparam int POST_RAMP_LOW_NS     = 100;
	localparam int PRE_ENABLE_CLOCKS    = 5;
	localparam int NOP_IDLE_US          = 200;
	localparam int POST_RESET_IDLE_US   = 1;
	localparam int AUTO_INIT_MAX_US     = 10;
	localparam int INIT_CAL_US          = 1;
	// Least times round up, longest times round down
	localparam int POST_RAMP_LOW_CYC    = (POST_RAMP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRE_ENABLE_CYC       = PRE_ENABLE_CLOCKS * LINK_PERIOD_CYC;
	localparam int NOP_IDLE_CYC         = (NOP_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POST_RESET_IDLE_CYC  = (POST_RESET_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AUTO_INIT_MAX_CYC    = (AUTO_INIT_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int INIT_CAL_CYC         = (INIT_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Device-side completion times, inside the longest allowed figures
	localparam int DEV_AUTO_INIT_NS     = 2000;
	localparam int DEV_CAL_NS           = 500;
	localparam int DEV_AUTO_INIT_CYC    = DEV_AUTO_INIT_NS / CLK_PERIOD_NS;
	localparam int DEV_CAL_CYC          = DEV_CAL_NS / CLK_PERIOD_NS;
	// Command codes on the link
	localparam logic [2:0] CMD_NOP      = 3'h0;
	localparam logic [2:0] CMD_MODE_WR  = 3'h1;
	localparam logic [2:0] CMD_MODE_RD  = 3'h2;
	localparam logic [2:0] CMD_PREA     = 3'h3;
	// Mode register addresses and operand values
	localparam logic [7:0] MA_DEVICE_INFO = 8'h00;
	localparam logic [7:0] MA_FEATURE_ONE = 8'h01;
	localparam logic [7:0] MA_LATENCY_CFG = 8'h02;
	localparam logic [7:0] MA_IO_CFG      = 8'h03;
	localparam logic [7:0] MA_IO_CALIB    = 8'h0A;
	localparam logic [7:0] MA_RESET       = 8'h3F;
	localparam logic [7:0] OP_CAL_INIT    = 8'hFF;
	localparam logic [7:0] OP_ZERO        = 8'h00;
	// Device info fields
	localparam int AUTO_INIT_BIT        = 0;
	localparam int SELFTEST_LO          = 3;
	localparam logic [1:0] SELFTEST_OK  = 2'h3;
	localparam logic [1:0] SELFTEST_NONE = 2'h0;
	// Controller register map, byte addresses
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h4;
	localparam logic [3:0] REG_MODE_CFG = 4'h8;
	localparam int CTRL_START           = 0;
	localparam int CTRL_POWER_OFF       = 1;
	localparam int CTRL_REINIT          = 2;
	localparam logic [23:0] MODE_CFG_RESET = 24'h00_0000;
endpackage

/* File: testbench/lpi_link_monitor.sv */
// Concurrent checks on the controller-to-device link
`timescale 1ns/1ps
module lpi_link_monitor
	import lpi_pkg::*;
#(
	parameter int NOP_IDLE_CYCLES = NOP_IDLE_CYC
) (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       ck,
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic [2:0] cmd,
	input wire logic [7:0] ma,
	input wire logic [7:0] op,
	input wire logic [7:0] dq_out,
	input wire logic       dq_oe,
	input wire logic [7:0] dq_in
);
	// Saturation keeps long runs from wrapping the counters
	localparam int SAT = 32'h0010_0000;
	int   low_q;
	int   ckr_q;
	int   hi_q;
	int   rst_q;
	int   cal_q;
	logic ck_q;
	wire  is_rst  = cke && cmd == CMD_MODE_WR && ma == MA_RESET;
	wire  is_cal  = cke && cmd == CMD_MODE_WR && ma == MA_IO_CALIB;
	wire  ck_rise = ck && !ck_q;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ck_q <= 1'h0;
			low_q <= 0;
			ckr_q <= 0;
			hi_q <= 0;
			rst_q <= SAT;
			cal_q <= SAT;
		end else begin
			ck_q <= ck;
			low_q <= cke ? 0 : low_q + (low_q < SAT);
			ckr_q <= cke ? 0 : ckr_q + (ck_rise && ckr_q < SAT);
			hi_q <= !cke ? 0 : hi_q + (hi_q < SAT);
			rst_q <= is_rst ? 0 : rst_q + (rst_q < SAT);
			cal_q <= is_cal ? 0 : cal_q + (cal_q < SAT);
		end
	end
	cke_low_time_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(cke) |-> low_q >= POST_RAMP_LOW_CYC) else $error("cke rose too early");
	clock_before_cke_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(cke) |-> ckr_q >= PRE_ENABLE_CLOCKS) else $error("too few link clocks before cke");
	nop_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		cke && hi_q < NOP_IDLE_CYCLES |-> cmd == CMD_NOP) else $error("command inside idle period");
	reset_after_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(is_rst) |-> hi_q >= NOP_IDLE_CYCLES) else $error("reset command too early");
	post_reset_nop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!is_rst && rst_q < POST_RESET_IDLE_CYC |-> cmd == CMD_NOP) else $error("command after reset");
	cal_after_wait_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(is_cal) |-> rst_q >= POST_RESET_IDLE_CYC) else $error("calibration too early");
	cal_wait_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!is_cal && cal_q < INIT_CAL_CYC |-> cmd == CMD_NOP) else $error("command during calibration");
	float_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!cke [*4] |-> !dq_oe) else $error("data driven while cke low");
	boot_clock_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || !cke)
		$rose(ck) |-> ck [*5] ##1 !ck [*5]) else $error("link clock period wrong");
	cmd_on_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(cmd) && cke && $past(cke) |-> !ck) else $error("command changed while ck high");
endmodule

/* File: testbench/sdram_powerup_init_sequence_test.sv */
// Bench: controller joined to device, plus a device driven by the bench
`timescale 1ns/1ps
module sdram_powerup_init_sequence_test;
	import lpi_pkg::*;
	logic        clk_in = 1'h0;
	logic        rst_n_in = 1'h0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rdy1;
	logic        bsy2;
	logic        bad2;
	logic [1:0]  st1;
	logic [7:0]  f1, l1, i1, f2;
	logic [31:0] rd;
	logic [7:0]  q8;
	int          err_count = 0;
	int          tests_run = 0;
	int          bad_n = 0;
	int          n;
	realtime     t0;
	lpi_link_if link ();
	lpi_link_if link2 ();
	lpi_ctrl #(.NOP_IDLE_CYCLES(200)) lpi_ctrl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
	lpi_device lpi_device_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .ready_out(rdy1),
		.auto_init_busy_out(), .bad_cmd_out(), .cal_resistor_selftest_out(st1), .feature_one_out(f1),
		.latency_cfg_out(l1), .io_cfg_out(i1));
	lpi_device lpi_device2_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link2), .ready_out(),
		.auto_init_busy_out(bsy2), .bad_cmd_out(bad2), .cal_resistor_selftest_out(), .feature_one_out(f2),
		.latency_cfg_out(), .io_cfg_out());
	lpi_link_monitor #(.NOP_IDLE_CYCLES(200)) lpi_link_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.ck(link.ck), .cke(link.cke), .cs_n(link.cs_n), .cmd(link.cmd), .ma(link.ma), .op(link.op),
		.dq_out(link.dq_out), .dq_oe(link.dq_oe), .dq_in(link.dq_in));
	always #4 clk_in = ~clk_in;
	always @(posedge clk_in) if (bad2 === 1'h1) bad_n++;
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Waitrequest and read data are taken at the rising edge, before it updates them
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
	endtask
	task automatic wait_state(input logic [3:0] s, input bit eq);
		for (int k = 0; k < 3000; k++) begin
			av(1'h0, REG_STATUS, 32'h0000_0000);
			if ((rd[3:0] === s) == eq) break;
		end
	endtask
	// One 160 ns link period per command; read data taken late in the high half
	task automatic lk(input logic [2:0] c, input logic [7:0] a, input logic [7:0] o);
		@(posedge clk_in);
		link2.ck  <= 1'h0;
		link2.cmd <= c;
		link2.ma  <= a;
		link2.op  <= o;
		repeat (10) @(posedge clk_in);
		link2.ck <= 1'h1;
		repeat (9) @(posedge clk_in);
		q8 = link2.dq_in;
	endtask
	initial begin
		repeat (60000) @(posedge clk_in);
		err_count++;
		conclude();
	end
	initial begin
		link2.ck = 1'h0;
		link2.cke = 1'h0;
		link2.cs_n = 1'h0;
		link2.cmd = CMD_NOP;
		link2.ma = 8'h00;
		link2.op = 8'h00;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'h1;
		@(negedge clk_in);
		chk("cke_reset", 32'h0000_0000, link.cke);
		av(1'h1, REG_MODE_CFG, 32'h0033_2211);
		av(1'h0, REG_MODE_CFG, 32'h0000_0000);
		chk("mode_cfg", 32'h0033_2211, rd);
		av(1'h0, 4'hC, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		av(1'h1, REG_CTRL, 32'h0000_0001);
		wait_state(4'hD, 1'h1);
		chk("state_ready", 32'h0000_000D, rd[3:0]);
		chk("poll_timeout", 32'h0000_0000, rd[4]);
		chk("info_flag", 32'h0000_0000, rd[8]);
		chk("dev_ready", 32'h0000_0001, rdy1);
		chk("selftest", SELFTEST_OK, st1);
		chk("mode_regs", 32'h0033_2211, {i1, l1, f1});
		chk("cs_sel", 32'h0000_0000, link.cs_n);
		av(1'h1, REG_CTRL, 32'h0000_0004);
		wait_state(4'hD, 1'h0);
		chk("reinit_step", 32'h0000_0001, rd[3:0] >= 4'h3 && rd[3:0] <= 4'h5);
		wait_state(4'h6, 1'h1);
		chk("regs_cleared", 32'h0000_0000, {i1, l1, f1});
		wait_state(4'hD, 1'h1);
		chk("mode_regs_again", 32'h0033_2211, {i1, l1, f1});
		chk("cke_held", 32'h0000_0001, link.cke);
		av(1'h1, REG_CTRL, 32'h0000_0002);
		wait_state(4'h0, 1'h1);
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		chk("cke_off", 32'h0000_0000, link.cke);
		chk("float_off", 32'h0000_0000, link.dq_oe);
		repeat (6) lk(CMD_NOP, 8'h00, 8'h00);
		lk(CMD_MODE_RD, MA_DEVICE_INFO, 8'h00);
		chk("read_cke_low", 32'h0000_0000, q8);
		link2.cke <= 1'h1;
		repeat (3) lk(CMD_NOP, 8'h00, 8'h00);
		t0 = $realtime;
		lk(CMD_MODE_WR, MA_RESET, 8'h00);
		repeat (7) lk(CMD_NOP, 8'h00, 8'h00);
		lk(CMD_MODE_RD, MA_DEVICE_INFO, 8'h00);
		chk("busy_flag", 32'h0000_0001, q8[AUTO_INIT_BIT]);
		lk(CMD_MODE_WR, MA_FEATURE_ONE, 8'h5A);
		repeat (2) lk(CMD_NOP, 8'h00, 8'h00);
		chk("refused_pulse", 32'h0000_0001, bad_n);
		chk("refused_reg", 32'h0000_0000, f2);
		for (n = 0; n < 60; n++) begin
			lk(CMD_MODE_RD, MA_DEVICE_INFO, 8'h00);
			if (q8[AUTO_INIT_BIT] === 1'h0) break;
		end
		chk("init_done", 32'h0000_0000, q8[AUTO_INIT_BIT]);
		chk("init_time", 32'h0000_0001, $realtime - t0 <= AUTO_INIT_MAX_US * 1000);
		chk("busy_out", 32'h0000_0000, bsy2);
		lk(CMD_MODE_WR, MA_FEATURE_ONE, 8'h5A);
		lk(CMD_NOP, 8'h00, 8'h00);
		chk("idle_accept", 32'h0000_005A, f2);
		chk("no_extra_pulse", 32'h0000_0001, bad_n);
		conclude();
	end
endmodule
